// file: rtl/cond_mon_pkg.sv
`default_nettype none
package cond_mon_pkg;
   localparam int NUM_ENTRIES = 16;
   localparam int VALUE_W = 16;
   localparam int LOC_W = 16;
   localparam logic [7:0] REQ_PROGRAM = 8'h53;
   localparam logic [7:0] REQ_POLL = 8'h54;
   localparam logic [7:0] CC_SUPPRESS = 8'hFF;
   localparam logic [7:0] CC_INIT_BASE = 8'h70;
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_FULL = 8'h01;
   localparam logic [7:0] STATUS_BAD_CODE = 8'h02;
   localparam logic [3:0] CMP_EQ = 4'h1;
   localparam logic [3:0] CMP_NE = 4'h2;
   localparam logic [3:0] CMP_GT = 4'h3;
   localparam logic [3:0] CMP_LT = 4'h4;
   localparam logic [3:0] CMP_OUT = 4'h5;
   localparam logic [3:0] CMP_IN = 4'h6;
   localparam real HALF_SEC_S = 0.5;
   localparam real CLOCK_HZ = 125.0e6;
   localparam int HALF_SEC_CYCLES = int'(HALF_SEC_S * CLOCK_HZ);
   localparam logic [7:0] VAR_RATE_HALF_SECS = 8'h01;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] condition_control_code;
      logic [7:0] sample_interval;
      logic [7:0] element_type;
      logic [15:0] element_location;
      logic [15:0] compare_operand_lo;
      logic [15:0] compare_operand_hi;
   } request_t;

   typedef struct packed {
      logic [7:0] condition_control_code;
      logic [7:0] element_type;
      logic [15:0] element_location;
      logic [15:0] value;
   } report_t;

   typedef struct packed {
      logic valid;
      logic [7:0] condition_control_code;
      logic [7:0] sample_interval;
      logic [7:0] element_type;
      logic [15:0] element_location;
      logic [15:0] compare_operand_lo;
      logic [15:0] compare_operand_hi;
   } entry_t;
endpackage : cond_mon_pkg
`default_nettype wire

// file: rtl/cond_entry_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cond_entry_mem #(
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input wire cond_mon_pkg::entry_t wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output cond_mon_pkg::entry_t rd_data
);
   import cond_mon_pkg::*;
   entry_t mem_ff [DEPTH];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
      end else if (wr_en) begin
         mem_ff[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_ff[rd_idx];
      end
   end
endmodule : cond_entry_mem
`default_nettype wire

// file: rtl/condition_monitor_engine.sv
`timescale 1ns/1ps
`default_nettype none
module condition_monitor_engine #(
   parameter int ENTRIES = cond_mon_pkg::NUM_ENTRIES,
   parameter int TICK_CYCLES = cond_mon_pkg::HALF_SEC_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire cond_mon_pkg::request_t req_data,
   output logic req_ready,
   output logic sample_req,
   output logic [cond_mon_pkg::LOC_W-1:0] sample_location,
   output logic [7:0] sample_type,
   input wire logic sample_ack,
   input wire logic [cond_mon_pkg::VALUE_W-1:0] sample_value,
   output logic resp_start,
   output logic [7:0] resp_code,
   output logic [7:0] resp_status,
   output logic resp_initiated,
   output logic rpt_valid,
   output cond_mon_pkg::report_t rpt_data,
   output logic resp_end
);
   import cond_mon_pkg::*;
   localparam int IW = $clog2(ENTRIES);

   if (ENTRIES < 2 || ENTRIES > 256 || TICK_CYCLES < 1) begin : g_bad_params
      $error("condition_monitor_engine: bad parameters");
   end

   typedef enum {S_IDLE, S_PROG_SCAN, S_PROG_LAST, S_PROG_ANS, S_SAMPLE_RD, S_SAMPLE_WAIT,
                 S_SAMPLE_REQ, S_SAMPLE_ACK, S_POLL_HDR, S_POLL_RD, S_POLL_WAIT,
                 S_POLL_EMIT, S_POLL_END} state_t;
   state_t state_ff;

   logic mem_wr;
   logic [IW-1:0] mem_wr_idx, mem_rd_idx, idx_ff, free_idx_ff, match_idx_ff;
   logic [IW-1:0] smp_idx_ff, nxt_smp_idx, scan_pos;
   logic scan_live;
   entry_t mem_wr_data, rd_entry;
   logic found_match_ff, found_free_ff, initiated_ff;
   request_t req_ff;
   logic [ENTRIES-1:0] active_ff;
   logic [VALUE_W-1:0] value_ff [ENTRIES];
   logic [7:0] age_ff [ENTRIES];
   logic [31:0] tick_cnt_ff;
   logic tick_ff;

   cond_entry_mem #(.DEPTH(ENTRIES)) u_mem (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(mem_wr),
      .wr_idx(mem_wr_idx),
      .wr_data(mem_wr_data),
      .rd_idx(mem_rd_idx),
      .rd_data(rd_entry)
   );

   // half-second tick
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
         tick_ff <= 1'b0;
      end
   end

   // compare kind is low nibble; 7x codes initiate
   function automatic logic cond_hit(input entry_t e, input logic [VALUE_W-1:0] v);
      logic hit;
      hit = 1'b0;
      unique case (e.condition_control_code[3:0])
         CMP_EQ: hit = (v == e.compare_operand_lo);
         CMP_NE: hit = (v != e.compare_operand_lo);
         CMP_GT: hit = (v > e.compare_operand_lo);
         CMP_LT: hit = (v < e.compare_operand_lo);
         CMP_OUT: hit = (v < e.compare_operand_lo) || (v > e.compare_operand_hi);
         CMP_IN: hit = (v > e.compare_operand_lo) && (v < e.compare_operand_hi);
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : cond_hit

   function automatic logic code_ok(input logic [7:0] cc);
      logic [3:0] k;
      k = cc[3:0];
      return (cc == CC_SUPPRESS) ||
             ((cc[7:4] == 4'h0 || cc[7:4] == CC_INIT_BASE[7:4]) && k >= CMP_EQ && k <= CMP_IN);
   endfunction : code_ok

   logic code_valid;
   assign code_valid = code_ok(req_ff.condition_control_code);
   assign mem_rd_idx = idx_ff;
   assign nxt_smp_idx = (smp_idx_ff == IW'(ENTRIES - 1)) ? '0 : smp_idx_ff + IW'(1);
   // scan data trails the read index by one cycle
   assign scan_pos = (state_ff == S_PROG_LAST) ? idx_ff : idx_ff - IW'(1);
   assign scan_live = (state_ff == S_PROG_LAST) || (idx_ff != '0);

   // entry writes
   always_comb begin
      mem_wr = 1'b0;
      mem_wr_idx = found_match_ff ? match_idx_ff : free_idx_ff;
      mem_wr_data = '0;
      if (state_ff == S_PROG_ANS && code_valid) begin
         if (req_ff.condition_control_code == CC_SUPPRESS) begin
            mem_wr = found_match_ff;
         end else if (found_match_ff || found_free_ff) begin
            mem_wr = 1'b1;
            mem_wr_data.valid = 1'b1;
            mem_wr_data.condition_control_code = req_ff.condition_control_code;
            mem_wr_data.sample_interval = req_ff.sample_interval;
            mem_wr_data.element_type = req_ff.element_type;
            mem_wr_data.element_location = req_ff.element_location;
            mem_wr_data.compare_operand_lo = req_ff.compare_operand_lo;
            mem_wr_data.compare_operand_hi = req_ff.compare_operand_hi;
         end
      end
   end

   logic [7:0] interval;
   assign interval = (rd_entry.sample_interval == 8'h00) ? VAR_RATE_HALF_SECS
                                                         : rd_entry.sample_interval;

   // main sequencer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         req_ff <= '0;
         idx_ff <= '0;
         smp_idx_ff <= '0;
         free_idx_ff <= '0;
         match_idx_ff <= '0;
         found_match_ff <= 1'b0;
         found_free_ff <= 1'b0;
         initiated_ff <= 1'b0;
         active_ff <= '0;
         for (int i = 0; i < ENTRIES; i++) begin
            value_ff[i] <= '0;
            age_ff[i] <= '0;
         end
         req_ready <= 1'b0;
         sample_req <= 1'b0;
         sample_location <= '0;
         sample_type <= '0;
         resp_start <= 1'b0;
         resp_code <= '0;
         resp_status <= '0;
         resp_initiated <= 1'b0;
         rpt_valid <= 1'b0;
         rpt_data <= '0;
         resp_end <= 1'b0;
      end else begin
         resp_start <= 1'b0;
         rpt_valid <= 1'b0;
         resp_end <= 1'b0;
         req_ready <= 1'b0;
         if (tick_ff) begin
            for (int i = 0; i < ENTRIES; i++) begin
               if (age_ff[i] != 8'hFF) begin
                  age_ff[i] <= age_ff[i] + 8'h01;
               end
            end
         end
         unique case (state_ff)
            S_IDLE: begin
               if (req_valid && (req_data.opcode == REQ_PROGRAM)) begin
                  req_ff <= req_data;
                  req_ready <= 1'b1;
                  idx_ff <= '0;
                  found_match_ff <= 1'b0;
                  found_free_ff <= 1'b0;
                  state_ff <= S_PROG_SCAN;
               end else if (req_valid && (req_data.opcode == REQ_POLL)) begin
                  req_ready <= 1'b1;
                  initiated_ff <= 1'b0;
                  state_ff <= S_POLL_HDR;
               end else if (req_valid) begin
                  req_ready <= 1'b1; // other codes are not ours
               end else begin
                  idx_ff <= smp_idx_ff;
                  state_ff <= S_SAMPLE_RD;
               end
            end
            S_PROG_SCAN, S_PROG_LAST: begin
               if (rd_entry.valid && scan_live &&
                   rd_entry.element_location == req_ff.element_location &&
                   rd_entry.element_type == req_ff.element_type) begin
                  found_match_ff <= 1'b1;
                  match_idx_ff <= scan_pos;
               end
               if (!rd_entry.valid && scan_live && !found_free_ff) begin
                  found_free_ff <= 1'b1;
                  free_idx_ff <= scan_pos;
               end
               if (state_ff == S_PROG_LAST) begin
                  state_ff <= S_PROG_ANS;
               end else if (idx_ff == IW'(ENTRIES - 1)) begin
                  state_ff <= S_PROG_LAST;
               end else begin
                  idx_ff <= idx_ff + IW'(1);
               end
            end
            S_PROG_ANS: begin
               // whole table seen, answer and commit
               resp_start <= 1'b1;
               resp_end <= 1'b1;
               resp_code <= REQ_PROGRAM;
               resp_initiated <= 1'b0;
               if (!code_valid) begin
                  resp_status <= STATUS_BAD_CODE;
               end else if (req_ff.condition_control_code == CC_SUPPRESS ||
                            found_match_ff || found_free_ff) begin
                  resp_status <= STATUS_OK;
               end else begin
                  resp_status <= STATUS_FULL;
               end
               if (mem_wr) begin
                  active_ff[mem_wr_idx] <= 1'b0;
                  age_ff[mem_wr_idx] <= '0;
               end
               idx_ff <= '0;
               state_ff <= S_IDLE;
            end
            S_SAMPLE_RD: state_ff <= S_SAMPLE_WAIT;
            S_SAMPLE_WAIT: begin
               if (rd_entry.valid && age_ff[idx_ff] >= interval) begin
                  sample_req <= 1'b1;
                  sample_location <= rd_entry.element_location;
                  sample_type <= rd_entry.element_type;
                  state_ff <= S_SAMPLE_ACK;
               end else begin
                  smp_idx_ff <= nxt_smp_idx;
                  state_ff <= S_IDLE;
               end
            end
            S_SAMPLE_ACK: begin
               if (sample_ack) begin
                  sample_req <= 1'b0;
                  age_ff[idx_ff] <= '0;
                  smp_idx_ff <= nxt_smp_idx;
                  value_ff[idx_ff] <= sample_value;
                  active_ff[idx_ff] <= cond_hit(rd_entry, sample_value);
                  if (cond_hit(rd_entry, sample_value) &&
                      rd_entry.condition_control_code[7:4] == CC_INIT_BASE[7:4]) begin
                     initiated_ff <= 1'b1;
                     state_ff <= S_POLL_HDR;
                  end else begin
                     state_ff <= S_IDLE;
                  end
               end
            end
            S_POLL_HDR: begin
               resp_start <= 1'b1;
               resp_code <= REQ_POLL;
               resp_status <= STATUS_OK;
               resp_initiated <= initiated_ff;
               idx_ff <= '0;
               state_ff <= S_POLL_RD;
            end
            S_POLL_RD: state_ff <= S_POLL_WAIT;
            S_POLL_WAIT: begin
               // initiated answers carry initiated kinds only
               if (rd_entry.valid && active_ff[idx_ff] && (!initiated_ff ||
                   rd_entry.condition_control_code[7:4] == CC_INIT_BASE[7:4])) begin
                  rpt_valid <= 1'b1;
                  rpt_data.condition_control_code <= rd_entry.condition_control_code;
                  rpt_data.element_type <= rd_entry.element_type;
                  rpt_data.element_location <= rd_entry.element_location;
                  rpt_data.value <= value_ff[idx_ff];
               end
               state_ff <= S_POLL_EMIT;
            end
            S_POLL_EMIT: begin
               idx_ff <= idx_ff + IW'(1);
               state_ff <= (idx_ff == IW'(ENTRIES - 1)) ? S_POLL_END : S_POLL_RD;
            end
            S_POLL_END: begin
               resp_end <= 1'b1;
               idx_ff <= '0;
               initiated_ff <= 1'b0;
               state_ff <= S_IDLE;
            end
         endcase
      end
   end
endmodule : condition_monitor_engine
`default_nettype wire

// file: test/sample_source.sv
`timescale 1ns/1ps
`default_nettype none
module sample_source (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sample_req,
   input wire logic [15:0] sample_location,
   output logic sample_ack,
   output logic [15:0] sample_value
);
   logic [15:0] mem [16];
   logic [2:0] gap_ff;
   logic [2:0] free_ff;
   // varying answer delay; released value line toggles
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sample_ack <= 1'b0;
         sample_value <= 16'h0000;
         gap_ff <= 3'h0;
         free_ff <= 3'h0;
      end else begin
         free_ff <= free_ff + 3'h1;
         sample_ack <= 1'b0;
         sample_value <= ~sample_value;
         if (sample_ack) gap_ff <= free_ff;
         else if (gap_ff != 3'h0) gap_ff <= gap_ff - 3'h1;
         else if (sample_req) begin
            sample_ack <= 1'b1;
            sample_value <= mem[sample_location[3:0]];
         end
      end
   end
endmodule : sample_source
`default_nettype wire

// file: test/monitor_engine_properties.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_props
   import cond_mon_pkg::*;
#(parameter int ENTRIES = 16) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req_ready,
   input wire cond_mon_pkg::request_t req_data,
   input wire logic sample_req,
   input wire logic [cond_mon_pkg::LOC_W-1:0] sample_location,
   input wire logic sample_ack,
   input wire logic resp_start,
   input wire logic [7:0] resp_code,
   input wire logic resp_initiated,
   input wire logic rpt_valid,
   input wire cond_mon_pkg::report_t rpt_data,
   input wire logic resp_end
);
   logic in_resp_ff;
   logic [4:0] rpt_cnt_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         in_resp_ff <= 1'b0;
         rpt_cnt_ff <= 5'h00;
      end else if (resp_start) begin
         in_resp_ff <= !resp_end;
         rpt_cnt_ff <= {4'h0, rpt_valid};
      end else begin
         if (resp_end) in_resp_ff <= 1'b0;
         if (rpt_valid) rpt_cnt_ff <= rpt_cnt_ff + 5'h01;
      end
   end
   property p_prog_ack;
      req_ready && req_data.opcode == REQ_PROGRAM |->
         ##[1:100] (resp_start && !resp_initiated && resp_code == REQ_PROGRAM);
   endproperty
   a_prog_ack: assert property (p_prog_ack) else $error("program unanswered");
   property p_prog_short;
      resp_start && resp_code == REQ_PROGRAM |-> resp_end && !rpt_valid;
   endproperty
   a_prog_short: assert property (p_prog_short) else $error("program answer long");
   property p_poll_ans;
      req_ready && req_data.opcode == REQ_POLL |->
         ##[1:200] (resp_start && !resp_initiated && resp_code == REQ_POLL);
   endproperty
   a_poll_ans: assert property (p_poll_ans) else $error("poll unanswered");
   property p_resp_end;
      resp_start && !resp_end |-> ##[1:200] resp_end;
   endproperty
   a_resp_end: assert property (p_resp_end) else $error("answer not closed");
   property p_init_fmt;
      resp_start && resp_initiated |-> resp_code == REQ_POLL;
   endproperty
   a_init_fmt: assert property (p_init_fmt) else $error("initiated format");
   property p_init_kind;
      rpt_valid && resp_initiated |-> rpt_data.condition_control_code[7:4] == 4'h7;
   endproperty
   a_init_kind: assert property (p_init_kind) else $error("poll kind initiated");
   property p_rpt_inside;
      rpt_valid |-> in_resp_ff || resp_start;
   endproperty
   a_rpt_inside: assert property (p_rpt_inside) else $error("stray report");
   property p_max_rpt;
      rpt_cnt_ff <= 5'(ENTRIES);
   endproperty
   a_max_rpt: assert property (p_max_rpt) else $error("too many reports");
   property p_sample_hold;
      sample_req && !sample_ack |=> sample_req && $stable(sample_location);
   endproperty
   a_sample_hold: assert property (p_sample_hold) else $error("sample dropped");
   c_prog: cover property (resp_start && resp_code == REQ_PROGRAM);
   c_poll_rpt: cover property (rpt_valid && !resp_initiated);
   c_init: cover property (resp_start && resp_initiated);
endmodule : monitor_props
bind condition_monitor_engine monitor_props #(.ENTRIES(ENTRIES)) props (.clock, .rst_n,
   .req_ready, .req_data, .sample_req, .sample_location, .sample_ack, .resp_start,
   .resp_code, .resp_initiated, .rpt_valid, .rpt_data, .resp_end);
`default_nettype wire

// file: test/tb_condition_monitor_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_condition_monitor_engine;
   import cond_mon_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   request_t req_data = '0;
   logic req_ready, sample_req, sample_ack, resp_start, resp_initiated, rpt_valid, resp_end;
   logic [15:0] sample_location, sample_value;
   logic [7:0] sample_type, resp_code, resp_status, last_status;
   report_t rpt_data;
   int errors = 0;
   int samples_checked = 0;
   int nrep = 0;
   int n_init = 0;
   int mi;
   integer seed = 32'h3d00;
   logic [7:0] mcc [16];
   logic [15:0] mlo [16];
   logic [15:0] mhi [16];
   bit mon [16];
   bit cur_init, poll_done, prog_done;
   always #4 clock = ~clock;
   condition_monitor_engine #(.TICK_CYCLES(10)) dut (.clock, .rst_n, .req_valid, .req_data,
      .req_ready, .sample_req, .sample_location, .sample_type, .sample_ack, .sample_value,
      .resp_start, .resp_code, .resp_status, .resp_initiated, .rpt_valid, .rpt_data, .resp_end);
   sample_source partner (.clock, .rst_n, .sample_req, .sample_location, .sample_ack,
      .sample_value);
   function automatic bit hit(input logic [7:0] cc, input logic [15:0] v, lo, hi);
      case (cc[3:0])
         CMP_EQ: return v == lo;
         CMP_NE: return v != lo;
         CMP_GT: return v > lo;
         CMP_LT: return v < lo;
         CMP_OUT: return v < lo || v > hi;
         CMP_IN: return v > lo && v < hi;
         default: return 1'b0;
      endcase
   endfunction : hit
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   always @(posedge clock) begin
      if (resp_start) begin
         cur_init = resp_initiated;
         nrep = 0;
         if (resp_initiated) n_init++;
         if (resp_code == REQ_PROGRAM) last_status = resp_status;
         if (resp_code == REQ_PROGRAM) prog_done = 1'b1;
      end
      if (rpt_valid) begin
         mi = int'(rpt_data.element_location[3:0]);
         nrep++;
         check(rpt_data.element_location, 16'h0100 + mi);
         check(rpt_data.element_type, mi[0] ? 8'h03 : 8'h05);
         check(rpt_data.condition_control_code, mcc[mi]);
         check(mon[mi], 1'b1);
         check(hit(mcc[mi], rpt_data.value, mlo[mi], mhi[mi]), 1'b1);
         if (cur_init) check(mcc[mi][7:4], 4'h7);
         else check(rpt_data.value, partner.mem[mi]);
      end
      if (resp_end && !cur_init && resp_code == REQ_POLL) poll_done = 1'b1;
      if (sample_req && sample_ack) check(sample_type, sample_location[0] ? 8'h03 : 8'h05);
   end
   task automatic send(input logic [7:0] op, cc, typ, input logic [15:0] loc, lo, hi);
      int k;
      prog_done = 1'b0;
      poll_done = 1'b0;
      k = 0;
      @(posedge clock);
      req_valid <= 1'b1;
      req_data <= '{op, cc, 8'($random(seed) & 1), typ, loc, lo, hi};
      @(posedge clock);
      while (req_ready !== 1'b1 && k < 4000) begin
         @(posedge clock);
         k++;
      end
      req_valid <= 1'b0;
      k = 0;
      while (!(prog_done || poll_done) && k < 400) begin
         @(negedge clock);
         k++;
      end
      check(k < 400, 1'b1);
   endtask : send
   task automatic prog(input int n, input logic [7:0] cc, st);
      logic [15:0] lo, hi;
      lo = 16'($random(seed) & 7);
      hi = lo + 16'($random(seed) & 7);
      send(REQ_PROGRAM, cc, n[0] ? 8'h03 : 8'h05, 16'h0100 + 16'(n), lo, hi);
      check(last_status, st);
      if (st == STATUS_OK) begin
         mcc[n] = cc;
         mlo[n] = lo;
         mhi[n] = hi;
         mon[n] = cc != CC_SUPPRESS;
      end
   endtask : prog
   task automatic poll_settled();
      int act;
      act = 0;
      repeat (3000) @(negedge clock);
      for (int j = 0; j < 16; j++) act += int'(mon[j] && hit(mcc[j], partner.mem[j], mlo[j], mhi[j]));
      send(REQ_POLL, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000);
      check(nrep, act);
   endtask : poll_settled
   initial begin
      for (int j = 0; j < 16; j++) partner.mem[j] = 16'h0000;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      poll_settled();
      for (int j = 0; j < 12; j++) prog(j, j < 6 ? 8'(j + 1) : 8'(j + 8'h6b), STATUS_OK);
      partner.mem[6] = mlo[6];
      repeat (4) begin
         poll_settled();
         for (int j = 0; j < 16; j++) partner.mem[j] = 16'($random(seed) & 7);
      end
      check(n_init > 0, 1'b1);
      for (int j = 12; j < 16; j++) prog(j, 8'h75, STATUS_OK);
      prog(16, 8'h01, STATUS_FULL);
      prog(3, 8'h76, STATUS_OK);
      prog(0, 8'h07, STATUS_BAD_CODE);
      poll_settled();
      for (int j = 0; j < 8; j++) prog(j, CC_SUPPRESS, STATUS_OK);
      poll_settled();
      for (int j = 8; j < 16; j++) prog(j, CC_SUPPRESS, STATUS_OK);
      poll_settled();
      close_out();
   end
   initial begin
      #(8 * 60000);
      errors++;
      close_out();
   end
endmodule : tb_condition_monitor_engine
`default_nettype wire
